// >>> logic/hfsr_pkg.sv
// package: register map, field positions and sizes for the link fifo status block
package hfsr_pkg;
  // register indices as printed; byte address is four times the index
  localparam logic [7:0] IDX_FIFO_FLAGS = 8'h1a;
  localparam logic [7:0] IDX_RESIDUE = 8'h1d;
  localparam logic [7:0] IDX_RX_COUNT_LOW = 8'h16;
  localparam logic [7:0] IDX_DATA_PORT = 8'h30;
  localparam logic [7:0] IDX_THRESHOLD = 8'h31;
  localparam logic [7:0] IDX_INT_ENABLE = 8'h32;
  localparam logic [7:0] IDX_INT_SOURCE = 8'h33;
  localparam logic [7:0] IDX_LINK_CTRL = 8'h34;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] RESIDUE_RESET = 8'h00;
  localparam logic [7:0] THRESHOLD_RESET = 8'h00;
  // fifo condition flag positions
  localparam int BIT_PKT_END = 5;
  localparam int BIT_TX_UNDER = 4;
  localparam int BIT_TX_SPACE = 3;
  localparam int BIT_TX_LEVEL = 2;
  localparam int BIT_RX_AVAIL = 1;
  localparam int BIT_RX_LEVEL = 0;
  // residue register fields
  localparam int BIT_RAW_ON = 7;
  localparam int BIT_RAW_SRC = 6;
  localparam int POS_TX_TAIL = 3;
  localparam int POS_RX_TAIL = 0;
  // interrupt source bit for fifo status
  localparam int BIT_INT_FIFO = 6;
  // link control fields (own register)
  localparam int BIT_LINK_RESET = 0;
  localparam int BIT_TX_LAST = 1;
  localparam int RX_DEPTH = 32;
  localparam int TX_DEPTH = 16;
  localparam int STACK_DEPTH = 4;
endpackage

// >>> logic/hfsr_mem.sv
// small byte memory with registered read data, used for the receive queue
`timescale 1ns/1ps
`default_nettype none
module hfsr_mem #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 32,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic clk_sys,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] store [DEPTH];
  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      store[wr_addr] <= wr_data;
    end
    rd_data <= store[rd_addr];
  end
endmodule
`default_nettype wire

// >>> logic/hfsr_top.sv
// link fifo status, data ports, residue and raw mode control behind an apb slave
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module hfsr_top
  import hfsr_pkg::*;
#(
  parameter int RX_DEPTH_P = hfsr_pkg::RX_DEPTH,
  parameter int TX_DEPTH_P = hfsr_pkg::TX_DEPTH
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_push,
  input wire logic [7:0] rx_push_data,
  input wire logic rx_push_last,
  input wire logic [2:0] rx_push_tail,
  input wire logic tx_pop,
  input wire logic tx_active,
  input wire logic [15:0] tx_byte_count,
  output logic [7:0] tx_pop_data,
  output logic tx_pop_last,
  output logic tx_queue_empty,
  output logic tx_send_abort,
  output logic tx_dma_request,
  output logic rx_overrun,
  output logic raw_mode_on,
  output logic raw_mode_control_source,
  output logic [2:0] tx_tail_bits,
  output logic fifo_irq_source
);
  import hfsr_pkg::*;

  localparam int RAW = $clog2(RX_DEPTH_P);
  localparam int TAW = $clog2(TX_DEPTH_P);

  function automatic logic [9:0] word_index(input logic [11:0] a);
    return a[11:2];
  endfunction

  function automatic logic is_idx(input logic [11:0] a, input logic [7:0] idx);
    return (a[1:0] == 2'h0) && (word_index(a) == {2'h0, idx});
  endfunction

  // apb: zero wait states, the access phase is the one that counts
  logic apb_wr, apb_rd;
  assign apb_wr = psel && penable && pwrite;
  assign apb_rd = psel && penable && !pwrite;

  // register state
  logic [7:0] thresh, next_thresh;
  logic [7:0] int_en, next_int_en;
  logic int_fifo_en, next_int_fifo_en;
  logic [7:0] ctrl_res, next_ctrl_res;
  logic [2:0] rx_tail_shown, next_rx_tail_shown;
  logic underflow, next_underflow;
  logic space_hold, next_space_hold;
  logic rx_inhibit, next_rx_inhibit;
  logic status_pending, next_status_pending;
  logic [7:0] flags, next_flags;
  logic irq_src, next_irq_src;
  logic [31:0] next_prdata;
  logic next_pslverr;
  logic link_reset;

  // receive queue: tag bit 8 marks the last byte of a packet
  logic [RAW-1:0] rx_wp, rx_rp, next_rx_wp, next_rx_rp;
  logic [RAW:0] rx_cnt, next_rx_cnt;
  logic [5:0] rx_tags, next_rx_tags;
  logic [8:0] rx_head;
  logic rx_do_push, rx_do_pop, rx_full;

  // transmit queue
  logic [8:0] tx_mem [TX_DEPTH_P];
  logic [TAW-1:0] tx_wp, tx_rp, next_tx_wp, next_tx_rp;
  logic [TAW:0] tx_cnt, next_tx_cnt;
  logic tx_do_push, tx_do_pop;
  logic tx_last_pending, next_tx_last_pending;

  // residue stack, four deep
  logic [2:0] stack [STACK_DEPTH];
  logic [2:0] next_stack [STACK_DEPTH];
  logic [2:0] stk_cnt, next_stk_cnt;
  logic stk_full;

  logic next_overrun, next_abort, next_dma;

  logic rd_data_port, wr_data_port, rd_flags, rd_residue, rd_count_low;
  assign rd_data_port = apb_rd && is_idx(paddr, IDX_DATA_PORT);
  assign wr_data_port = apb_wr && is_idx(paddr, IDX_DATA_PORT);
  assign rd_flags = apb_rd && is_idx(paddr, IDX_FIFO_FLAGS);
  assign rd_residue = apb_rd && is_idx(paddr, IDX_RESIDUE);
  assign rd_count_low = apb_rd && is_idx(paddr, IDX_RX_COUNT_LOW);
  assign link_reset = apb_wr && is_idx(paddr, IDX_LINK_CTRL) && pwdata[BIT_LINK_RESET];

  assign rx_full = (rx_cnt == (RAW+1)'(RX_DEPTH_P));
  assign stk_full = (stk_cnt == 3'(STACK_DEPTH));
  // a full status stack makes the receiver drop a new packet's last byte
  assign rx_do_push = rx_push && !rx_full && !(stk_full && rx_push_last);
  // the next packet's data can be read but is not popped while the previous status is unread
  assign rx_do_pop = rd_data_port && (rx_cnt != '0) && !status_pending;
  assign tx_do_push = wr_data_port && (tx_cnt != (TAW+1)'(TX_DEPTH_P));
  assign tx_do_pop = tx_pop && (tx_cnt != '0);

  hfsr_mem #(.WIDTH(9), .DEPTH(RX_DEPTH_P)) u_rx_mem (
    .clk_sys(clk_sys),
    .wr_en(rx_do_push),
    .wr_addr(rx_wp),
    .wr_data({rx_push_last, rx_push_data}),
    .rd_addr(next_rx_rp),
    .rd_data(rx_head)
  );

  always_ff @(posedge clk_sys) begin
    if (tx_do_push) begin
      tx_mem[tx_wp] <= {tx_last_pending, pwdata[7:0]};
    end
  end

  // queue pointers and counts
  always_comb begin
    next_rx_wp = rx_do_push ? rx_wp + 1'b1 : rx_wp;
    next_rx_rp = rx_do_pop ? rx_rp + 1'b1 : rx_rp;
    next_rx_cnt = rx_cnt + (RAW+1)'(rx_do_push) - (RAW+1)'(rx_do_pop);
    next_rx_tags = rx_tags + 6'(rx_do_push && rx_push_last) - 6'(rx_do_pop && rx_head[8]);
    next_tx_wp = tx_do_push ? tx_wp + 1'b1 : tx_wp;
    next_tx_rp = tx_do_pop ? tx_rp + 1'b1 : tx_rp;
    next_tx_cnt = tx_cnt + (TAW+1)'(tx_do_push) - (TAW+1)'(tx_do_pop);
    // software marks the next written byte as a packet's last one
    next_tx_last_pending = tx_last_pending;
    if (apb_wr && is_idx(paddr, IDX_LINK_CTRL)) begin
      next_tx_last_pending = pwdata[BIT_TX_LAST];
    end else if (tx_do_push) begin
      next_tx_last_pending = 1'b0;
    end
    if (link_reset) begin
      next_rx_wp = '0;
      next_rx_rp = '0;
      next_rx_cnt = '0;
      next_rx_tags = '0;
      next_tx_wp = '0;
      next_tx_rp = '0;
      next_tx_cnt = '0;
      next_tx_last_pending = 1'b0;
    end
  end

  // residue stack and packet status handshake
  always_comb begin
    for (int i = 0; i < STACK_DEPTH; i++) begin
      next_stack[i] = stack[i];
    end
    next_stk_cnt = stk_cnt;
    next_status_pending = status_pending;
    next_rx_tail_shown = rx_tail_shown;
    if (rd_residue || rd_count_low) begin
      next_rx_tail_shown = 3'h0;
    end
    if (rd_count_low) begin
      next_status_pending = 1'b0;
    end
    // pop the oldest entry when its packet's final byte is read
    if (rx_do_pop && rx_head[8] && stk_cnt != 3'h0) begin
      next_rx_tail_shown = stack[0];
      next_status_pending = 1'b1;
      for (int i = 0; i < STACK_DEPTH - 1; i++) begin
        next_stack[i] = stack[i+1];
      end
      next_stk_cnt = next_stk_cnt - 3'h1;
    end
    if (rx_do_push && rx_push_last) begin
      next_stack[next_stk_cnt[1:0]] = rx_push_tail;
      next_stk_cnt = next_stk_cnt + 3'h1;
    end
    if (link_reset) begin
      next_stk_cnt = 3'h0;
      next_status_pending = 1'b0;
      next_rx_tail_shown = 3'h0;
    end
  end

  // control registers
  always_comb begin
    next_thresh = thresh;
    next_int_en = int_en;
    next_int_fifo_en = int_fifo_en;
    next_ctrl_res = ctrl_res;
    if (apb_wr && is_idx(paddr, IDX_THRESHOLD)) begin
      next_thresh = pwdata[7:0];
    end
    if (apb_wr && is_idx(paddr, IDX_INT_ENABLE)) begin
      next_int_en = pwdata[7:0] & 8'h3f;
      next_int_fifo_en = pwdata[8];
    end
    // tx tail bits change only by a residue write, a link reset or rstn; nothing else clears them
    if (apb_wr && is_idx(paddr, IDX_RESIDUE)) begin
      next_ctrl_res = {pwdata[7:3], 3'h0};
    end
    if (link_reset) begin
      next_thresh = THRESHOLD_RESET;
      next_int_en = 8'h00;
      next_int_fifo_en = 1'b0;
      next_ctrl_res = RESIDUE_RESET;
    end
  end

  // flag conditions
  always_comb begin
    next_underflow = underflow;
    next_space_hold = space_hold;
    next_rx_inhibit = rx_inhibit;
    if (rd_flags) begin
      next_underflow = 1'b0;
    end
    // a new underflow in the read cycle still wins
    if (tx_active && tx_do_pop && !tx_do_push && tx_cnt == (TAW+1)'(1) && tx_byte_count != 16'h0000) begin
      next_underflow = 1'b1;
    end
    if (tx_cnt == '0 && tx_byte_count != 16'h0000) begin
      next_space_hold = 1'b1;
    end
    if (tx_do_push && tx_last_pending) begin
      next_space_hold = 1'b0;
    end
    if (rd_count_low) begin
      next_rx_inhibit = 1'b0;
    end
    if (rx_do_pop && rx_head[8]) begin
      next_rx_inhibit = 1'b1;
    end
    if (link_reset) begin
      next_underflow = 1'b0;
      next_space_hold = 1'b0;
      next_rx_inhibit = 1'b0;
    end
    next_flags = FLAGS_RESET;
    next_flags[BIT_PKT_END] = (next_rx_tags != '0);
    next_flags[BIT_TX_UNDER] = next_underflow;
    next_flags[BIT_TX_SPACE] = next_space_hold && (next_tx_cnt != (TAW+1)'(TX_DEPTH_P));
    next_flags[BIT_TX_LEVEL] = ({{(8-TAW-1){1'b0}}, next_tx_cnt} <= {4'h0, next_thresh[3:0]});
    next_flags[BIT_RX_AVAIL] = (next_rx_cnt != '0) && !next_rx_inhibit;
    next_flags[BIT_RX_LEVEL] = (next_thresh[7:4] != 4'h0) &&
      ({{(8-RAW-1){1'b0}}, next_rx_cnt} >= {4'h0, next_thresh[7:4]});
    // source bit sets on a rising enabled flag, set beats the read clear
    next_irq_src = irq_src;
    if (apb_rd && is_idx(paddr, IDX_INT_SOURCE)) begin
      next_irq_src = 1'b0;
    end
    if (|(next_flags & ~flags & int_en) && int_fifo_en) begin
      next_irq_src = 1'b1;
    end
    if (link_reset) begin
      next_irq_src = 1'b0;
    end
    next_overrun = rx_push && rx_full;
    next_abort = next_underflow && !underflow;
    next_dma = next_flags[BIT_TX_LEVEL] && next_space_hold;
  end

  // read data and error answer
  always_comb begin
    next_prdata = 32'h0000_0000;
    next_pslverr = 1'b0;
    if (psel && !penable) begin
      case (1'b1)
        is_idx(paddr, IDX_FIFO_FLAGS): next_prdata = {24'h0, flags};
        is_idx(paddr, IDX_RESIDUE): next_prdata = {24'h0, ctrl_res[7:3], rx_tail_shown};
        is_idx(paddr, IDX_RX_COUNT_LOW): next_prdata = 32'h0000_0000;
        is_idx(paddr, IDX_DATA_PORT): next_prdata = (rx_cnt != '0) ? {24'h0, rx_head[7:0]} : 32'h0000_0000;
        is_idx(paddr, IDX_THRESHOLD): next_prdata = {24'h0, thresh};
        is_idx(paddr, IDX_INT_ENABLE): next_prdata = {23'h0, int_fifo_en, int_en};
        is_idx(paddr, IDX_INT_SOURCE): next_prdata = {24'h0, 1'b0, irq_src, 6'h0};
        is_idx(paddr, IDX_LINK_CTRL): next_prdata = {30'h0, tx_last_pending, 1'b0};
        default: next_pslverr = 1'b1;
      endcase
    end else if (psel && penable) begin
      next_prdata = prdata;
      next_pslverr = pslverr;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rx_wp <= '0;
      rx_rp <= '0;
      rx_cnt <= '0;
      rx_tags <= '0;
      tx_wp <= '0;
      tx_rp <= '0;
      tx_cnt <= '0;
      tx_last_pending <= 1'b0;
      for (int i = 0; i < STACK_DEPTH; i++) begin
        stack[i] <= 3'h0;
      end
      stk_cnt <= 3'h0;
      status_pending <= 1'b0;
      rx_tail_shown <= 3'h0;
      thresh <= THRESHOLD_RESET;
      int_en <= 8'h00;
      int_fifo_en <= 1'b0;
      ctrl_res <= RESIDUE_RESET;
      underflow <= 1'b0;
      space_hold <= 1'b0;
      rx_inhibit <= 1'b0;
      flags <= FLAGS_RESET;
      irq_src <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
      pready <= 1'b0;
      rx_overrun <= 1'b0;
      tx_send_abort <= 1'b0;
      tx_dma_request <= 1'b0;
      tx_pop_data <= 8'h00;
      tx_pop_last <= 1'b0;
      tx_queue_empty <= 1'b1;
      raw_mode_on <= 1'b0;
      raw_mode_control_source <= 1'b0;
      tx_tail_bits <= 3'h0;
      fifo_irq_source <= 1'b0;
    end else begin
      rx_wp <= next_rx_wp;
      rx_rp <= next_rx_rp;
      rx_cnt <= next_rx_cnt;
      rx_tags <= next_rx_tags;
      tx_wp <= next_tx_wp;
      tx_rp <= next_tx_rp;
      tx_cnt <= next_tx_cnt;
      tx_last_pending <= next_tx_last_pending;
      stack <= next_stack;
      stk_cnt <= next_stk_cnt;
      status_pending <= next_status_pending;
      rx_tail_shown <= next_rx_tail_shown;
      thresh <= next_thresh;
      int_en <= next_int_en;
      int_fifo_en <= next_int_fifo_en;
      ctrl_res <= next_ctrl_res;
      underflow <= next_underflow;
      space_hold <= next_space_hold;
      rx_inhibit <= next_rx_inhibit;
      flags <= next_flags;
      irq_src <= next_irq_src;
      prdata <= next_prdata;
      pslverr <= next_pslverr;
      pready <= psel && !penable;
      rx_overrun <= next_overrun;
      tx_send_abort <= next_abort;
      tx_dma_request <= next_dma;
      tx_pop_data <= tx_mem[next_tx_rp][7:0];
      tx_pop_last <= tx_mem[next_tx_rp][8];
      tx_queue_empty <= (next_tx_cnt == '0);
      raw_mode_on <= next_ctrl_res[BIT_RAW_ON];
      // the source choice means nothing outside raw mode, so it is held low there
      raw_mode_control_source <= next_ctrl_res[BIT_RAW_ON] && next_ctrl_res[BIT_RAW_SRC];
      tx_tail_bits <= next_ctrl_res[POS_TX_TAIL +: 3];
      fifo_irq_source <= next_irq_src;
    end
  end
endmodule
`default_nettype wire

// >>> sim/hfsr_asserts.sv
// assertion checker for the fifo status block, bound to its top module
`timescale 1ns/1ps
`default_nettype none
module hfsr_asserts
  import hfsr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rx_push,
  input wire logic tx_pop,
  input wire logic tx_queue_empty,
  input wire logic tx_send_abort,
  input wire logic rx_overrun,
  input wire logic raw_mode_on,
  input wire logic raw_mode_control_source,
  input wire logic [2:0] tx_tail_bits
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);
  sequence s_acc;
    psel && penable;
  endsequence
  sequence s_wr(logic [7:0] idx);
    psel && penable && pwrite && paddr == {2'b00, idx, 2'b00};
  endsequence
  chk_zero_wait:
    assert property (s_acc |-> pready) else $error("access without ready");
  chk_ready_pulse:
    assert property (pready |=> !pready) else $error("ready held too long");
  chk_err_align:
    assert property (psel && penable && paddr[1:0] != 2'b00 |-> pslverr && prdata == 32'h0) else $error("bad refuse");
  chk_flags_top:
    assert property (s_acc ##0 !pwrite && paddr == {2'b00, IDX_FIFO_FLAGS, 2'b00} |-> prdata[31:6] == 26'h0)
      else $error("flag top bits set");
  chk_tail_write:
    assert property (s_wr(IDX_RESIDUE) |=> tx_tail_bits == $past(pwdata[5:3]) && raw_mode_on == $past(pwdata[7]))
      else $error("residue write lost");
  chk_src_gated:
    assert property (!raw_mode_on |-> !raw_mode_control_source) else $error("source while raw off");
  chk_src_follow:
    assert property (s_wr(IDX_RESIDUE) ##1 raw_mode_on |-> raw_mode_control_source == $past(pwdata[6]))
      else $error("source wrong");
  chk_abort_pulse:
    assert property (tx_send_abort |=> !tx_send_abort) else $error("abort not a pulse");
  chk_abort_empty:
    assert property (tx_send_abort |-> tx_queue_empty) else $error("abort with data queued");
  chk_overrun_cause:
    assert property (rx_overrun |-> $past(rx_push)) else $error("overrun without push");
  chk_tx_enqueue:
    assert property (s_wr(IDX_DATA_PORT) ##0 (tx_queue_empty && !tx_pop) |=> !tx_queue_empty)
      else $error("write not queued");
endmodule
bind hfsr_top hfsr_asserts chk_u (.clk_sys, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .rx_push, .tx_pop, .tx_queue_empty, .tx_send_abort, .rx_overrun, .raw_mode_on,
  .raw_mode_control_source, .tx_tail_bits);
`default_nettype wire

// >>> sim/hfsr_link_model.sv
// link-side model: feeds the receive queue and drains the transmit queue
`timescale 1ns/1ps
`default_nettype none
module hfsr_link_model (
  input wire logic clk_sys,
  input wire logic [7:0] tx_pop_data,
  input wire logic tx_pop_last,
  input wire logic tx_send_abort,
  input wire logic rx_overrun,
  output logic rx_push,
  output logic [7:0] rx_push_data,
  output logic rx_push_last,
  output logic [2:0] rx_push_tail,
  output logic tx_pop,
  output logic tx_active,
  output logic [15:0] tx_byte_count
);
  int n_abort = 0;
  int n_over = 0;
  initial begin
    rx_push = 1'b0;
    rx_push_data = 8'h00;
    rx_push_last = 1'b0;
    rx_push_tail = 3'h0;
    tx_pop = 1'b0;
    tx_active = 1'b0;
    tx_byte_count = 16'h0000;
  end
  // the serial side notices each abort it is told to send
  always @(posedge clk_sys) begin
    n_abort <= n_abort + int'(tx_send_abort === 1'b1);
    n_over <= n_over + int'(rx_overrun === 1'b1);
  end
  task automatic push(input logic [7:0] d, input logic l, input logic [2:0] t);
    @(posedge clk_sys);
    rx_push <= 1'b1;
    rx_push_data <= d;
    rx_push_last <= l;
    rx_push_tail <= t;
    @(posedge clk_sys);
    rx_push <= 1'b0;
    // idle data lines must not look valid
    rx_push_data <= ~d;
    rx_push_last <= ~l;
    rx_push_tail <= ~t;
  endtask
  task automatic pop(input int gap, output logic [7:0] d, output logic l);
    repeat (gap + 1) @(posedge clk_sys);
    d = tx_pop_data;
    l = tx_pop_last;
    tx_pop <= 1'b1;
    @(posedge clk_sys);
    tx_pop <= 1'b0;
  endtask
  task automatic set_tx(input logic a, input logic [15:0] c);
    @(posedge clk_sys);
    tx_active <= a;
    tx_byte_count <= c;
  endtask
endmodule
`default_nettype wire

// >>> sim/hfsr_top_tb.sv
// self-checking bench for the link fifo status block
`timescale 1ns/1ps
`default_nettype none
module hfsr_top_tb
  import hfsr_pkg::*;
  ;
  localparam logic [11:0] A_FLG = {2'b00, IDX_FIFO_FLAGS, 2'b00};
  localparam logic [11:0] A_RES = {2'b00, IDX_RESIDUE, 2'b00};
  localparam logic [11:0] A_CNT = {2'b00, IDX_RX_COUNT_LOW, 2'b00};
  localparam logic [11:0] A_DAT = {2'b00, IDX_DATA_PORT, 2'b00};
  localparam logic [11:0] A_IEN = {2'b00, IDX_INT_ENABLE, 2'b00};
  localparam logic [11:0] A_CTL = {2'b00, IDX_LINK_CTRL, 2'b00};
  localparam logic [31:0] FE = 32'h1 << BIT_PKT_END;
  localparam logic [31:0] FU = 32'h1 << BIT_TX_UNDER;
  localparam logic [31:0] FS = 32'h1 << BIT_TX_SPACE;
  localparam logic [31:0] FL = 32'h1 << BIT_TX_LEVEL;
  localparam logic [31:0] FA = 32'h1 << BIT_RX_AVAIL;
  localparam logic [31:0] FR = 32'h1 << BIT_RX_LEVEL;
  logic clk_sys, rstn, psel, penable, pwrite, pready, pslverr, rx_push, rx_push_last, tx_pop, tx_active;
  logic tx_pop_last, tx_queue_empty, tx_send_abort, tx_dma_request, rx_overrun, raw_mode_on;
  logic raw_mode_control_source, fifo_irq_source;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0] rx_push_data, tx_pop_data;
  logic [2:0] rx_push_tail, tx_tail_bits;
  logic [15:0] tx_byte_count;
  int err_count = 0;
  int n_checks = 0;
  hfsr_top dut_u (.clk_sys, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .rx_push, .rx_push_data, .rx_push_last, .rx_push_tail, .tx_pop, .tx_active, .tx_byte_count,
    .tx_pop_data, .tx_pop_last, .tx_queue_empty, .tx_send_abort, .tx_dma_request, .rx_overrun,
    .raw_mode_on, .raw_mode_control_source, .tx_tail_bits, .fifo_irq_source);
  hfsr_link_model lk_u (.clk_sys, .tx_pop_data, .tx_pop_last, .tx_send_abort, .rx_overrun, .rx_push,
    .rx_push_data, .rx_push_last, .rx_push_tail, .tx_pop, .tx_active, .tx_byte_count);
  task automatic stop_test();
    if (err_count == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [32:0] r);
    int n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 40);
    if (n >= 40) begin
      err_count++;
    end
    r = {pslverr, prdata};
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [32:0] r;
    apb(1'b1, a, d, r);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    logic [32:0] r;
    apb(1'b0, a, 32'h0, r);
    chk(r[31:0], exp);
  endtask
  task automatic t_reset();
    logic [32:0] r;
    apb(1'b0, A_FLG, 32'h0, r);
    chk(r[31:0] & ~FL, 32'(FLAGS_RESET));
    rdc(A_RES, 32'(RESIDUE_RESET));
    chk(32'(tx_queue_empty), 32'h1);
    apb(1'b0, 12'h069, 32'h0, r);
    chk(32'(r[32]), 32'h1);
    chk(r[31:0], 32'h0);
  endtask
  task automatic t_rx();
    wr({2'b00, IDX_THRESHOLD, 2'b00}, 32'h30);
    lk_u.push(8'ha1, 1'b0, 3'h0);
    lk_u.push(8'hb2, 1'b0, 3'h0);
    lk_u.push(8'hc3, 1'b1, 3'h5);
    rdc(A_FLG, FE | FA | FR | FL);
    rdc(A_DAT, 32'ha1);
    rdc(A_FLG, FE | FA | FL);
    rdc(A_DAT, 32'hb2);
    rdc(A_DAT, 32'hc3);
    lk_u.push(8'hd4, 1'b1, 3'h2);
    rdc(A_FLG, FE | FL);
    rdc(A_RES, 32'h5);
    rdc(A_RES, 32'h0);
    // status still unread: the head shows but must not leave the queue
    rdc(A_DAT, 32'hd4);
    rdc(A_CNT, 32'h0);
    rdc(A_FLG, FE | FA | FL);
    rdc(A_DAT, 32'hd4);
    rdc(A_FLG, FL);
    rdc(A_CNT, 32'h0);
    rdc(A_RES, 32'h0);
  endtask
  task automatic t_tx();
    logic [7:0] d;
    logic l;
    lk_u.set_tx(1'b0, 16'h2);
    rdc(A_FLG, FS | FL);
    chk(32'(tx_dma_request), 32'h1);
    wr(A_DAT, 32'h5a);
    wr(A_CTL, 32'h2);
    wr(A_DAT, 32'h3c);
    rdc(A_FLG, 32'h0);
    chk(32'(tx_dma_request), 32'h0);
    lk_u.set_tx(1'b1, 16'h2);
    lk_u.pop(0, d, l);
    chk({23'h0, l, d}, 32'h05a);
    // a slow link: the last byte goes after a stall
    lk_u.pop(3, d, l);
    chk({23'h0, l, d}, 32'h13c);
    repeat (3) @(posedge clk_sys);
    chk(32'(lk_u.n_abort), 32'h1);
    rdc(A_FLG, FU | FS | FL);
    rdc(A_FLG, FS | FL);
    lk_u.set_tx(1'b0, 16'h0);
    wr(A_CTL, 32'h1);
    rdc(A_FLG, FL);
  endtask
  task automatic t_irq();
    wr(A_IEN, 32'h002);
    lk_u.push(8'h11, 1'b0, 3'h0);
    repeat (3) @(posedge clk_sys);
    chk(32'(fifo_irq_source), 32'h0);
    rdc(A_DAT, 32'h11);
    wr(A_IEN, 32'h102);
    lk_u.push(8'h22, 1'b0, 3'h0);
    repeat (3) @(posedge clk_sys);
    chk(32'(fifo_irq_source), 32'h1);
    rdc({2'b00, IDX_INT_SOURCE, 2'b00}, 32'h40);
    @(posedge clk_sys);
    chk(32'(fifo_irq_source), 32'h0);
    rdc(A_DAT, 32'h22);
    wr(A_IEN, 32'h0);
  endtask
  task automatic t_raw();
    for (int i = 0; i < 8; i++) begin
      wr(A_RES, 32'(i) << 3);
      rdc(A_RES, 32'(i) << 3);
    end
    wr(A_RES, 32'he8);
    rdc(A_RES, 32'he8);
    chk({27'h0, raw_mode_on, raw_mode_control_source, tx_tail_bits}, 32'h1d);
    wr(A_RES, 32'h48);
    @(posedge clk_sys);
    chk({27'h0, raw_mode_on, raw_mode_control_source, tx_tail_bits}, 32'h01);
  endtask
  task automatic t_over();
    for (int i = 0; i < RX_DEPTH; i++) begin
      lk_u.push(8'(i), 1'b0, 3'h0);
    end
    chk(32'(lk_u.n_over), 32'h0);
    lk_u.push(8'hee, 1'b0, 3'h0);
    // the model counts the pulse one edge after it stands
    repeat (2) @(posedge clk_sys);
    chk(32'(lk_u.n_over), 32'h1);
    rdc(A_DAT, 32'h00);
    wr(A_CTL, 32'h1);
  endtask
  task automatic t_stack();
    // five one-byte packets: the fifth finds the status stack full and is dropped
    for (int i = 1; i <= 5; i++) begin
      lk_u.push(8'(i), 1'b1, 3'(i));
    end
    for (int i = 1; i <= 4; i++) begin
      rdc(A_DAT, 32'(i));
      rdc(A_RES, 32'(i));
      rdc(A_CNT, 32'h0);
    end
    rdc(A_FLG, FL);
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    #100000;
    err_count++;
    stop_test();
  end
  initial begin
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (4) @(posedge clk_sys);
    rstn <= 1'b1;
    t_reset();
    t_rx();
    t_tx();
    t_irq();
    t_raw();
    t_over();
    t_stack();
    stop_test();
  end
endmodule
`default_nettype wire
